// ---- hw/fper_pkg.sv ----
/*
  Shared constants for the flash page-erase / row-program sequencer:
  register byte offsets, control field positions, operation codes,
  unlock key values, array geometry and state enumerations.
  Assumes a 32-bit AXI4-Lite register port, one aligned word per register.
*/
package fper_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_LATCH = 8'h10;
  localparam logic [7:0] OFS_TABLE_READ_OP = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ************************************************************
  // control fields, codes and keys
  // ************************************************************
  localparam int unsigned CTL_START_BIT = 15;
  localparam int unsigned CTL_PROGRAM_ENABLE_BIT = 14;
  localparam int unsigned CTL_ERASE_BIT = 6;
  localparam int unsigned STS_REFUSED_BIT = 1;
  localparam int unsigned PAGE_SPACE_BIT = 7;
  localparam logic [3:0] OP_ROW_PROG = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] OPSEL_RESET = 4'h0;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned FLASH_WORDS = 4096;
  localparam int unsigned FLASH_AW = 12;
  localparam int unsigned ROW_WORDS = 64;
  localparam int unsigned ROW_AW = 6;
  localparam int unsigned PAGE_AW = 9;
  localparam int unsigned CFG_WORDS = 8;
  localparam int unsigned CFG_AW = 3;
  localparam int unsigned CFG_WRITABLE = 6;
  localparam logic [8:0] WALK_LAST_ERASE = 9'h1FF;
  localparam logic [8:0] WALK_LAST_ROW = 9'h03F;

  // ************************************************************
  // state enumerations
  // ************************************************************
  typedef enum logic [1:0] {FPER_IDLE, FPER_ERASE, FPER_PROG, FPER_SETTLE} fper_state_e;
  typedef enum logic [1:0] {FPER_KEY_NONE, FPER_KEY_HALF, FPER_KEY_OPEN} fper_key_e;

endpackage : fper_pkg

// ---- hw/fper_flash_seq.sv ----
/*
  Flash sequencer: program-flash array, 64-entry row write latches,
  configuration words, unlock logic and erase/program state machine,
  reached over an AXI4-Lite slave port.
  Assumes one clock (aclk), synchronous active-low reset, and that the
  cpu_stall output is honoured by the processor outside.
*/
// Chosen here: the AXI4-Lite register port and the placing of the registers.
// Summary of operation
// - erase always covers the whole eight-row page
// - operation code 0010 selects page erase
// - 0x55 then 0xAA key unlocks any operation
// - start bit after unlock launches the cycle
// - cpu stalled for the whole erase
// - cpu stalled for the whole row program
// - hardware clears start bit on completion
// - code 0001, erase clear, enable set programs
// - 64 latched instructions written as one row
// - table page bit 7 reaches configuration space
`timescale 1ns/1ps
`default_nettype none

module fper_flash_seq #(
  parameter int unsigned ERASE_SETTLE_CYCLES = 32, // extra cycles after page walk
  parameter int unsigned ROW_SETTLE_CYCLES = 16,   // extra cycles after row walk
  parameter logic [23:0] DEVICE_ID_WORD = 24'h00A5C3, // arbitrary value
  parameter logic [23:0] REVISION_WORD = 24'h000001   // arbitrary value
) (
  input wire logic aclk,                 // system clock
  input wire logic aresetn,              // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr,   // write address
  input wire logic s_axi_awvalid,        // write address valid
  output logic s_axi_awready,            // write address ready
  input wire logic [31:0] s_axi_wdata,   // write data
  input wire logic [3:0] s_axi_wstrb,    // write byte strobes
  input wire logic s_axi_wvalid,         // write data valid
  output logic s_axi_wready,             // write data ready
  output logic [1:0] s_axi_bresp,        // write response
  output logic s_axi_bvalid,             // write response valid
  input wire logic s_axi_bready,         // write response ready
  input wire logic [7:0] s_axi_araddr,   // read address
  input wire logic s_axi_arvalid,        // read address valid
  output logic s_axi_arready,            // read address ready
  output logic [31:0] s_axi_rdata,       // read data
  output logic [1:0] s_axi_rresp,        // read response
  output logic s_axi_rvalid,             // read data valid
  input wire logic s_axi_rready,         // read data ready
  output logic cpu_stall                 // processor held while high
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam int unsigned FLASH_AW_L = fper_pkg::FLASH_AW;
  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;
  logic rd_mapped;
  logic wr_fire;
  logic wr_mapped;
  logic wr_ctl, wr_key, wr_page, wr_offset, wr_latch, wr_status;
  logic [31:0] wr_merged;
  logic [3:0] opsel_reg;
  logic erase_reg;
  logic program_enable_reg;
  logic start_reg;
  logic refused_reg;
  logic [7:0] table_page_reg;
  logic [15:0] table_offset_reg;
  logic [FLASH_AW_L-1:0] cur_word;
  logic [5:0] row_reg;
  logic [15:0] ctl_word;
  logic op_valid;
  logic launch;
  logic busy;
  logic walk_done;
  logic settle_done;
  logic [15:0] settle_last;
  logic [8:0] walk_cnt_reg;
  logic [15:0] settle_cnt_reg;
  logic [FLASH_AW_L-1:0] target_reg;
  logic [23:0] cfg_rd;
  logic [23:0] cfg_word [0:fper_pkg::CFG_WORDS-1];
  logic [23:0] flash_mem [0:fper_pkg::FLASH_WORDS-1];
  logic [23:0] latch_mem [0:fper_pkg::ROW_WORDS-1];
  fper_pkg::fper_state_e state_reg;
  fper_pkg::fper_key_e key_reg;

  // byte-lane merge of a write into the old register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ************************************************************
  // axi write channels
  // ************************************************************
  // writes are only committed while idle: this is what stalls the cpu's stores
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg && !busy;
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // address and data captured independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // write decode
  assign wr_ctl = wr_fire && (aw_addr_reg == fper_pkg::OFS_CONTROL);
  assign wr_key = wr_fire && (aw_addr_reg == fper_pkg::OFS_KEY);
  assign wr_page = wr_fire && (aw_addr_reg == fper_pkg::OFS_PAGE);
  assign wr_offset = wr_fire && (aw_addr_reg == fper_pkg::OFS_OFFSET);
  assign wr_latch = wr_fire && (aw_addr_reg == fper_pkg::OFS_LATCH);
  assign wr_status = wr_fire && (aw_addr_reg == fper_pkg::OFS_STATUS);
  // offsets are contiguous aligned words from control up to status
  assign wr_mapped = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= fper_pkg::OFS_STATUS);
  assign ctl_word = {start_reg, program_enable_reg, 7'h00, erase_reg, 2'h0, opsel_reg};
  assign wr_merged = merge_bytes({16'h0000, ctl_word}, w_data_reg, w_strb_reg);

  // ************************************************************
  // unlock and launch
  // ************************************************************
  // every other write breaks the sequence, so the keys must be back to back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_reg <= fper_pkg::FPER_KEY_NONE;
    end
    else if (wr_key && w_strb_reg[0] && (w_data_reg[7:0] == fper_pkg::KEY_FIRST))
    begin
      key_reg <= fper_pkg::FPER_KEY_HALF;
    end
    else if (wr_key && w_strb_reg[0] && (w_data_reg[7:0] == fper_pkg::KEY_SECOND) &&
             (key_reg == fper_pkg::FPER_KEY_HALF))
    begin
      key_reg <= fper_pkg::FPER_KEY_OPEN;
    end
    else if (wr_fire)
    begin
      key_reg <= fper_pkg::FPER_KEY_NONE;
    end
  end

  // legal combinations: page erase or row program, both need enable
  assign op_valid = wr_merged[fper_pkg::CTL_PROGRAM_ENABLE_BIT] &&
                    (((wr_merged[3:0] == fper_pkg::OP_PAGE_ERASE) && wr_merged[fper_pkg::CTL_ERASE_BIT]) ||
                     ((wr_merged[3:0] == fper_pkg::OP_ROW_PROG) && !wr_merged[fper_pkg::CTL_ERASE_BIT]));
  assign launch = wr_ctl && wr_merged[fper_pkg::CTL_START_BIT] && op_valid &&
                  (key_reg == fper_pkg::FPER_KEY_OPEN);

  // control fields; start bit set by launch only, cleared by hardware
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opsel_reg <= fper_pkg::OPSEL_RESET;
      erase_reg <= 1'b0;
      program_enable_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        opsel_reg <= wr_merged[3:0];
        erase_reg <= wr_merged[fper_pkg::CTL_ERASE_BIT];
        program_enable_reg <= wr_merged[fper_pkg::CTL_PROGRAM_ENABLE_BIT];
      end
      if (launch)
      begin
        start_reg <= 1'b1;
      end
      else if ((state_reg == fper_pkg::FPER_SETTLE) && settle_done)
      begin
        start_reg <= 1'b0;
      end
    end
  end

  // sticky refusal flag, write one to clear, a new refusal wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      refused_reg <= 1'b0;
    end
    else if (wr_ctl && wr_merged[fper_pkg::CTL_START_BIT] && !launch)
    begin
      refused_reg <= 1'b1;
    end
    else if (wr_status && w_strb_reg[0] && w_data_reg[fper_pkg::STS_REFUSED_BIT])
    begin
      refused_reg <= 1'b0;
    end
  end

  // ************************************************************
  // table pointer, latches and configuration words
  // ************************************************************
  assign cur_word = table_offset_reg[FLASH_AW_L:1];

  // offset steps by one instruction after each latch write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      table_page_reg <= fper_pkg::PAGE_RESET;
      table_offset_reg <= fper_pkg::OFFSET_RESET;
      row_reg <= 6'h00;
    end
    else
    begin
      if (wr_page)
      begin
        table_page_reg <= w_strb_reg[0] ? w_data_reg[7:0] : table_page_reg;
      end
      if (wr_offset)
      begin
        table_offset_reg <= merge_bytes({16'h0000, table_offset_reg}, w_data_reg, w_strb_reg)[15:0];
      end
      else if (wr_latch)
      begin
        table_offset_reg <= table_offset_reg + 16'h0002;
      end
      if (wr_latch && !table_page_reg[fper_pkg::PAGE_SPACE_BIT])
      begin
        row_reg <= cur_word[FLASH_AW_L-1:fper_pkg::ROW_AW];
      end
    end
  end

  // row latches, indexed by the low instruction bits
  always_ff @(posedge aclk)
  begin
    if (wr_latch && !table_page_reg[fper_pkg::PAGE_SPACE_BIT])
    begin
      latch_mem[cur_word[fper_pkg::ROW_AW-1:0]] <= w_data_reg[23:0];
    end
  end

  // configuration words, writable part reached with page bit 7 set
  generate
    for (genvar g = 0; g < fper_pkg::CFG_WORDS; g++)
    begin : g_cfg
      if (g < fper_pkg::CFG_WRITABLE)
      begin : g_rw
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
          begin
            cfg_word[g] <= fper_pkg::ERASED_WORD;
          end
          else if (wr_latch && table_page_reg[fper_pkg::PAGE_SPACE_BIT] &&
                   (table_offset_reg[fper_pkg::CFG_AW:1] == 3'(g)))
          begin
            cfg_word[g] <= w_data_reg[23:0];
          end
        end
      end
      else
      begin : g_ro
        assign cfg_word[g] = (g == fper_pkg::CFG_WORDS - 1) ? REVISION_WORD : DEVICE_ID_WORD;
      end
    end
  endgenerate
  assign cfg_rd = cfg_word[table_offset_reg[fper_pkg::CFG_AW:1]];

  // ************************************************************
  // erase / program sequencer
  // ************************************************************
  assign busy = (state_reg != fper_pkg::FPER_IDLE);
  assign cpu_stall = busy;
  assign walk_done = (state_reg == fper_pkg::FPER_ERASE) ? (walk_cnt_reg == fper_pkg::WALK_LAST_ERASE) :
                     (walk_cnt_reg == fper_pkg::WALK_LAST_ROW);
  assign settle_last = erase_reg ? 16'(ERASE_SETTLE_CYCLES - 1) : 16'(ROW_SETTLE_CYCLES - 1);
  assign settle_done = (settle_cnt_reg == settle_last);

  // one word per cycle, then a settle wait before the start bit drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= fper_pkg::FPER_IDLE;
      walk_cnt_reg <= 9'h000;
      settle_cnt_reg <= 16'h0000;
      target_reg <= '0;
    end
    else
    begin
      case (state_reg)
        fper_pkg::FPER_IDLE:
        begin
          walk_cnt_reg <= 9'h000;
          settle_cnt_reg <= 16'h0000;
          if (launch)
          begin
            state_reg <= wr_merged[fper_pkg::CTL_ERASE_BIT] ? fper_pkg::FPER_ERASE : fper_pkg::FPER_PROG;
            target_reg <= wr_merged[fper_pkg::CTL_ERASE_BIT] ? cur_word : {row_reg, 6'h00};
          end
        end
        fper_pkg::FPER_ERASE, fper_pkg::FPER_PROG:
        begin
          walk_cnt_reg <= walk_cnt_reg + 9'h001;
          if (walk_done)
          begin
            state_reg <= fper_pkg::FPER_SETTLE;
          end
        end
        fper_pkg::FPER_SETTLE:
        begin
          settle_cnt_reg <= settle_cnt_reg + 16'h0001;
          if (settle_done)
          begin
            state_reg <= fper_pkg::FPER_IDLE;
          end
        end
        default:
        begin
          state_reg <= fper_pkg::FPER_IDLE;
        end
      endcase
    end
  end

  // array update: whole page erased, or whole row copied from latches
  always_ff @(posedge aclk)
  begin
    if (state_reg == fper_pkg::FPER_ERASE)
    begin
      flash_mem[{target_reg[FLASH_AW_L-1:fper_pkg::PAGE_AW], walk_cnt_reg}] <= fper_pkg::ERASED_WORD;
    end
    else if (state_reg == fper_pkg::FPER_PROG)
    begin
      flash_mem[{target_reg[FLASH_AW_L-1:fper_pkg::ROW_AW], walk_cnt_reg[5:0]}] <=
        latch_mem[walk_cnt_reg[5:0]];
    end
  end

  // ************************************************************
  // axi read channel
  // ************************************************************
  // read mux; table reads pick array or configuration space
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      fper_pkg::OFS_CONTROL: rd_word = {16'h0000, ctl_word};
      fper_pkg::OFS_KEY: rd_word = 32'h00000000;
      fper_pkg::OFS_PAGE: rd_word = {24'h000000, table_page_reg};
      fper_pkg::OFS_OFFSET: rd_word = {16'h0000, table_offset_reg};
      fper_pkg::OFS_LATCH: rd_word = 32'h00000000;
      fper_pkg::OFS_TABLE_READ_OP: rd_word = {8'h00, table_page_reg[fper_pkg::PAGE_SPACE_BIT] ? cfg_rd :
                                      flash_mem[cur_word]};
      fper_pkg::OFS_STATUS: rd_word = {29'h00000000, (key_reg == fper_pkg::FPER_KEY_OPEN), refused_reg, busy};
      default: rd_mapped = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // one read in flight; data registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : fper_flash_seq

`default_nettype wire

// ---- verif/fper_flash_seq_checker.sv ----
/*
  Checker for the flash sequencer: bus answers, unlock and launch, stall length.
  Assumes it is bound to fper_flash_seq and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module fper_seq_checker #(
  parameter int unsigned ERASE_SETTLE_CYCLES = 32, // erase tail
  parameter int unsigned ROW_SETTLE_CYCLES = 16    // row tail
) (
  input wire logic aclk,                // clock
  input wire logic aresetn,             // reset, active low
  input wire logic [7:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,       // aw valid
  input wire logic s_axi_awready,       // aw ready
  input wire logic [31:0] s_axi_wdata,  // write data
  input wire logic [3:0] s_axi_wstrb,   // strobes
  input wire logic s_axi_wvalid,        // w valid
  input wire logic s_axi_wready,        // w ready
  input wire logic [1:0] s_axi_bresp,   // write response
  input wire logic s_axi_bvalid,        // b valid
  input wire logic s_axi_bready,        // b ready
  input wire logic [7:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,       // ar valid
  input wire logic s_axi_arready,       // ar ready
  input wire logic [31:0] s_axi_rdata,  // read data
  input wire logic [1:0] s_axi_rresp,   // read response
  input wire logic s_axi_rvalid,        // r valid
  input wire logic s_axi_rready,        // r ready
  input wire logic cpu_stall            // processor held
);
  // ************************************************************
  // helper state rebuilt from bus traffic
  // ************************************************************
  localparam int ERASE_TOTAL = 512 + ERASE_SETTLE_CYCLES;
  localparam int ROW_TOTAL = 64 + ROW_SETTLE_CYCLES;
  logic [7:0] aw_reg;
  logic [31:0] w_reg;
  logic [1:0] key_reg;
  logic [15:0] stall_reg;
  logic mode_ok;
  logic start_ok;

  // one write at a time, so the last taken address and data belong together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_reg <= 8'hFF;
    else if (s_axi_awvalid && s_axi_awready)
      aw_reg <= s_axi_awaddr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_reg <= 32'h0000_0000;
    else if (s_axi_wvalid && s_axi_wready)
      w_reg <= s_axi_wdata;
  end

  // key progress on each finished write; anything else breaks it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      key_reg <= 2'h0;
    else if (s_axi_bvalid && s_axi_bready)
      key_reg <= (aw_reg != 8'h04) ? 2'h0 : (w_reg[7:0] == 8'h55) ? 2'h1 :
                 (w_reg[7:0] == 8'hAA && key_reg == 2'h1) ? 2'h2 : 2'h0;
  end

  // length of the current stall
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cpu_stall)
      stall_reg <= 16'h0000;
    else
      stall_reg <= stall_reg + 16'h0001;
  end

  assign mode_ok = aw_reg == 8'h00 && w_reg[15] && w_reg[14] &&
                   ((w_reg[3:0] == 4'h2 && w_reg[6]) || (w_reg[3:0] == 4'h1 && !w_reg[6]));
  assign start_ok = mode_ok && key_reg == 2'h2;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stall_length: assert property ($fell(cpu_stall) |-> stall_reg == ERASE_TOTAL || stall_reg == ROW_TOTAL)
    else $error("stall length differs from a full cycle");
  a_stall_bound: assert property (cpu_stall |-> stall_reg < ERASE_TOTAL)
    else $error("stall runs past the longest cycle");
  a_launch_unlocked: assert property ($rose(cpu_stall) |-> key_reg == 2'h2)
    else $error("cycle started without both keys");
  a_launch_mode: assert property ($rose(cpu_stall) |-> mode_ok)
    else $error("cycle started with a bad mode");
  a_start_launches: assert property ($rose(s_axi_bvalid) && start_ok |-> cpu_stall)
    else $error("valid start did not launch");
  a_refuse_start: assert property ($rose(s_axi_bvalid) && aw_reg == 8'h00 && w_reg[15] && !start_ok |-> !cpu_stall)
    else $error("invalid start launched");
  a_write_held: assert property ($rose(s_axi_bvalid) |-> !$past(cpu_stall))
    else $error("write answered during stall");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'b00 |=>
    s_axi_rvalid && s_axi_rresp == (($past(s_axi_araddr) > 8'h18) ? 2'b10 : 2'b00))
    else $error("read answer late or wrong response");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  c_erase: cover property ($rose(cpu_stall) && w_reg[6]);
  c_program: cover property ($rose(cpu_stall) && !w_reg[6]);
  c_refused: cover property ($rose(s_axi_bvalid) && aw_reg == 8'h00 && w_reg[15] && !start_ok);
endmodule : fper_seq_checker

bind fper_flash_seq fper_seq_checker #(.ERASE_SETTLE_CYCLES(ERASE_SETTLE_CYCLES), .ROW_SETTLE_CYCLES(ROW_SETTLE_CYCLES))
  u_chk (.*);
`default_nettype wire

// ---- verif/fper_flash_seq_bench.sv ----
/*
  Bench for the flash sequencer: register tasks over AXI4-Lite, refusals,
  page erase, row program and configuration space.
  Assumes the design and its bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module fper_flash_seq_bench;
  localparam int unsigned ES = 3;
  localparam int unsigned RS = 2;
  localparam logic [23:0] DEV_ID = 24'h3C5A69; // arbitrary value
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_stall;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [31:0] bad_modes [4] = '{32'h0000_C002, 32'h0000_8042, 32'h0000_C041, 32'h0000_C000};
  int err_count, checks, cycles, stall_cycles, n;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

  fper_flash_seq #(.ERASE_SETTLE_CYCLES(ES), .ROW_SETTLE_CYCLES(RS), .DEVICE_ID_WORD(DEV_ID)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_stall(cpu_stall));

  always #12.5 aclk = ~aclk;

  // cycle watchdog and stall length count; a hang counts as a mismatch
  always @(posedge aclk)
  begin
    cycles++;
    if (cpu_stall === 1'b1)
      stall_cycles++;
    if (cycles > 6000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    wr_resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_data, e)
  endtask : rd_chk

  task automatic launch(input logic [31:0] c);
    wr(8'h04, 32'h0000_0055);
    wr(8'h04, 32'h0000_00AA);
    wr(8'h00, c);
    repeat (2) @(posedge aclk);
  endtask : launch

  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {err_count, checks, cycles, stall_cycles} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    `CHK(rd_resp, 2'b10)
    wr(8'h40, 32'h0000_0001);
    `CHK(wr_resp, 2'b10)
    // start with no keys, then with a write between the keys
    wr(8'h00, 32'h0000_C042);
    rd_chk(8'h18, 32'h0000_0002);
    wr(8'h18, 32'h0000_0002);
    wr(8'h04, 32'h0000_0055);
    wr(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0000_00AA);
    wr(8'h00, 32'h0000_C042);
    rd_chk(8'h18, 32'h0000_0002);
    wr(8'h18, 32'h0000_0002);
    // unlocked but wrong code or flags: start must stay clear
    for (int i = 0; i < 4; i++)
    begin
      launch(bad_modes[i]);
      rd_chk(8'h18, 32'h0000_0002);
      rd_chk(8'h00, bad_modes[i] & 32'h0000_7FFF);
      wr(8'h18, 32'h0000_0002);
    end
    // page erase of word 0x200; a write during the cycle is held off
    wr(8'h0C, 32'h0000_0400);
    wr(8'h04, 32'h0000_0055);
    wr(8'h04, 32'h0000_00AA);
    rd_chk(8'h18, 32'h0000_0004);
    n = stall_cycles;
    wr(8'h00, 32'h0000_C042);
    rd_chk(8'h00, 32'h0000_C042);
    rd_chk(8'h18, 32'h0000_0001);
    wr(8'h0C, 32'h0000_0400);
    `CHK(cpu_stall, 1'b0)
    `CHK(stall_cycles - n, 512 + ES)
    rd_chk(8'h00, 32'h0000_4042);
    rd_chk(8'h14, 32'h00FF_FFFF);
    wr(8'h0C, 32'h0000_07FE);
    rd_chk(8'h14, 32'h00FF_FFFF);
    // fill one row of latches, commit it, read it back
    wr(8'h0C, 32'h0000_0400);
    for (int i = 0; i < 64; i++)
      wr(8'h10, 32'h0000_A000 + i);
    n = stall_cycles;
    launch(32'h0000_C001);
    while (cpu_stall !== 1'b0) @(posedge aclk);
    `CHK(stall_cycles - n, 64 + RS)
    rd_chk(8'h00, 32'h0000_4001);
    for (int i = 0; i < 64; i++)
    begin
      wr(8'h0C, 32'h0000_0400 + 2 * i);
      rd_chk(8'h14, 32'h0000_A000 + i);
    end
    wr(8'h0C, 32'h0000_0480);
    rd_chk(8'h14, 32'h00FF_FFFF);
    // configuration space through table page bit 7
    wr(8'h08, 32'h0000_0080);
    wr(8'h0C, 32'h0000_000C);
    rd_chk(8'h14, {8'h00, DEV_ID});
    wr(8'h0C, 32'h0000_0002);
    wr(8'h10, 32'h0012_3456);
    wr(8'h0C, 32'h0000_0002);
    rd_chk(8'h14, 32'h0012_3456);
    tally_and_finish();
  end
endmodule : fper_flash_seq_bench
`default_nettype wire
